// ### inc/rsc_cfg.svh
// Offsets, field positions, reset values and timing of the strength/proximity register group
// Operation
// - AM peak strength code held in bits 7:4 until reception start or clear.
// - PM peak strength code held in bits 3:0 until reception start or clear.
// - Strength codes rise monotonically with input level; zero means lowest threshold.
// - Gain state bits 7:4 report total AM gain cut: setting, squelch, AGC.
// - Gain state bits 3:0 report total PM gain cut: setting, squelch, AGC.
// - Proximity control bits 7:3 are a binary weighted manual calibration value.
// - Manual field zero selects automatic calibration; nonzero applies the manual value.
// - Proximity display bits 7:3 show the calibration value in use, read-only.
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// Register indices; byte address is four times the index
`define RSC_IDX_STRENGTH 10'h02D
`define RSC_IDX_GAIN 10'h02E
`define RSC_IDX_PROX_CTRL 10'h02F
`define RSC_IDX_PROX_DISP 10'h030
`define RSC_IDX_IRQ_STATUS 10'h040
`define RSC_IDX_IRQ_ENABLE 10'h041
`define RSC_IDX_IRQ_CLEAR 10'h042
`define RSC_IDX_COMMAND 10'h043

// Field positions
`define RSC_AM_MSB 7
`define RSC_AM_LSB 4
`define RSC_PM_MSB 3
`define RSC_PM_LSB 0
`define RSC_CAL_MSB 7
`define RSC_CAL_LSB 3
`define RSC_GAIN_MSB 2
`define RSC_GAIN_LSB 0
`define RSC_DISP_END 2
`define RSC_DISP_ERR 1
`define RSC_CMD_CLEAR 0
`define RSC_CMD_CAL 1
`define RSC_IRQ_CAL_END 0
`define RSC_IRQ_CAL_ERR 1
`define RSC_IRQ_RX_START 2

// Reset values and gain cut saturation limit
`define RSC_PROX_CTRL_RST 8'h00
`define RSC_IRQ_ENABLE_RST 3'h0
`define RSC_GAIN_CUT_MAX 4'hF

// Comparator settle time per calibration step
`define RSC_CLK_NS 10
`define RSC_SETTLE_NS 1000
`define RSC_SETTLE_CYC ((`RSC_SETTLE_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)

`endif

// ### inc/rsc_pkg.sv
// Types of the strength/proximity register group
package rsc_pkg;

   typedef enum logic [1:0] {
      RSC_CAL_IDLE = 2'b00,
      RSC_CAL_SETTLE = 2'b01,
      RSC_CAL_DECIDE = 2'b10
   } rsc_cal_t;

   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] peak;
   } rsc_peak_t;

   typedef struct packed {
      logic [2:0] sync_rx;
      logic rx_level;
      logic [2:0] sync_cmp;
      logic cmp_level;
      logic [7:0] ctrl;
      rsc_cal_t cal_state;
      logic [4:0] cal_code;
      logic [2:0] cal_bit;
      logic [7:0] cal_cnt;
      logic cal_end;
      logic cal_err;
      logic cal_busy;
      logic [3:0] gain_am;
      logic [3:0] gain_pm;
      logic [2:0] irq_status;
      logic [2:0] irq_enable;
      logic irq;
      logic clr_peak;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } rsc_state_t;

endpackage : rsc_pkg

// ### hdl/rsc_peak_hold.sv
// Peak hold of one four-bit strength code coming from the analog receiver
`timescale 1ns/1ps
`include "rsc_cfg.svh"

module rsc_peak_hold
   import rsc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [3:0] code_in,
   input wire logic clear,
   output logic [3:0] peak
);

   rsc_peak_t s;
   rsc_peak_t next_s;

   always_comb begin
      next_s = s;
      next_s.s1 = code_in;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      // Codes are monotonic in level, so the largest code is the peak
      if (clear) begin
         next_s.peak = 4'h0;
      end else if (s.s2 == s.s3 && s.s3 > s.peak) begin
         next_s.peak = s.s3;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign peak = s.peak;

endmodule : rsc_peak_hold

// ### hdl/rsc_regs.sv
// APB register group: strength peaks, gain state, proximity sensor calibration
`timescale 1ns/1ps
`include "rsc_cfg.svh"

module rsc_regs
   import rsc_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [3:0] AM_STRENGTH_CODE,
   input wire logic [3:0] PM_STRENGTH_CODE,
   input wire logic RX_ACTIVE,
   input wire logic [3:0] AM_GAIN_CUT_SETTING,
   input wire logic [3:0] AM_SQUELCH_CUT,
   input wire logic [3:0] AM_AGC_CUT,
   input wire logic [3:0] PM_GAIN_CUT_SETTING,
   input wire logic [3:0] PM_SQUELCH_CUT,
   input wire logic [3:0] PM_AGC_CUT,
   input wire logic CAP_CMP,
   output logic [4:0] CAP_CAL_CODE,
   output logic [2:0] CAP_GAIN,
   output logic CAP_CAL_BUSY,
   output logic IRQ
);

   localparam logic [7:0] SETTLE_CYC = 8'(`RSC_SETTLE_CYC);

   rsc_state_t s;
   rsc_state_t next_s;

   logic [3:0] am_strength_peak;
   logic [3:0] pm_strength_peak;

   // Saturating sum of the three gain cut contributions
   function automatic logic [3:0] rsc_cut_sum(
      input logic [3:0] a,
      input logic [3:0] b,
      input logic [3:0] c
   );
      logic [5:0] sum;
      sum = {2'b00, a} + {2'b00, b} + {2'b00, c};
      if (sum > {2'b00, `RSC_GAIN_CUT_MAX}) begin
         rsc_cut_sum = `RSC_GAIN_CUT_MAX;
      end else begin
         rsc_cut_sum = sum[3:0];
      end
   endfunction : rsc_cut_sum

   rsc_peak_hold u_am_peak (
      .sys_clk(SYS_CLK),
      .rst_n(RST_N),
      .code_in(AM_STRENGTH_CODE),
      .clear(s.clr_peak),
      .peak(am_strength_peak)
   );

   rsc_peak_hold u_pm_peak (
      .sys_clk(SYS_CLK),
      .rst_n(RST_N),
      .code_in(PM_STRENGTH_CODE),
      .clear(s.clr_peak),
      .peak(pm_strength_peak)
   );

   logic setup;
   logic wr;
   logic [9:0] idx;
   logic mapped;
   logic rx_start;
   logic cmd_clear;
   logic cmd_cal;
   logic [2:0] irq_set;
   logic [2:0] irq_clr;
   logic [4:0] mask;
   logic [4:0] kept;
   logic [7:0] rd;

   always_comb begin
      next_s = s;
      setup = PSEL && !PENABLE;
      wr = PSEL && PENABLE && s.pready && PWRITE;
      idx = PADDR[11:2];
      rx_start = 1'b0;
      cmd_clear = 1'b0;
      cmd_cal = 1'b0;
      irq_set = 3'h0;
      irq_clr = 3'h0;
      mask = 5'h01 << s.cal_bit;
      kept = s.cal_code;
      rd = 8'h00;

      // Pin inputs: a change counts once stages two and three agree
      next_s.sync_rx = {s.sync_rx[1:0], RX_ACTIVE};
      next_s.sync_cmp = {s.sync_cmp[1:0], CAP_CMP};
      if (s.sync_rx[1] == s.sync_rx[2]) begin
         next_s.rx_level = s.sync_rx[2];
      end
      if (s.sync_cmp[1] == s.sync_cmp[2]) begin
         next_s.cmp_level = s.sync_cmp[2];
      end
      rx_start = !s.rx_level && next_s.rx_level;

      // Address decode, word aligned only
      mapped = (PADDR[1:0] == 2'b00) &&
         (idx == `RSC_IDX_STRENGTH || idx == `RSC_IDX_GAIN ||
          idx == `RSC_IDX_PROX_CTRL || idx == `RSC_IDX_PROX_DISP ||
          idx == `RSC_IDX_IRQ_STATUS || idx == `RSC_IDX_IRQ_ENABLE ||
          idx == `RSC_IDX_IRQ_CLEAR || idx == `RSC_IDX_COMMAND);

      // Register writes, taken in the access cycle
      if (wr && mapped) begin
         unique case (idx)
            `RSC_IDX_PROX_CTRL: begin
               // Gain codes are not checked; unused ones pass to the sensor
               next_s.ctrl = PWDATA[7:0];
            end
            `RSC_IDX_IRQ_ENABLE: begin
               next_s.irq_enable = PWDATA[2:0];
            end
            `RSC_IDX_IRQ_CLEAR: begin
               irq_clr = PWDATA[2:0];
            end
            `RSC_IDX_COMMAND: begin
               cmd_clear = PWDATA[`RSC_CMD_CLEAR];
               cmd_cal = PWDATA[`RSC_CMD_CAL];
            end
            default: begin
            end
         endcase
      end

      // Peaks restart from zero at reception start or on command
      next_s.clr_peak = rx_start || cmd_clear;

      // Total gain cut per channel
      next_s.gain_am = rsc_cut_sum(AM_GAIN_CUT_SETTING, AM_SQUELCH_CUT,
                                   AM_AGC_CUT);
      next_s.gain_pm = rsc_cut_sum(PM_GAIN_CUT_SETTING, PM_SQUELCH_CUT,
                                   PM_AGC_CUT);

      // Calibration sequencer
      unique case (s.cal_state)
         RSC_CAL_IDLE: begin
            if (cmd_cal) begin
               next_s.cal_end = 1'b0;
               next_s.cal_err = 1'b0;
               if (next_s.ctrl[`RSC_CAL_MSB:`RSC_CAL_LSB] != 5'h00) begin
                  // Manual value applies at once
                  next_s.cal_code = next_s.ctrl[`RSC_CAL_MSB:`RSC_CAL_LSB];
                  next_s.cal_end = 1'b1;
                  irq_set[`RSC_IRQ_CAL_END] = 1'b1;
               end else begin
                  // Successive approximation, heaviest bit first
                  next_s.cal_code = 5'h10;
                  next_s.cal_bit = 3'd4;
                  next_s.cal_cnt = SETTLE_CYC;
                  next_s.cal_busy = 1'b1;
                  next_s.cal_state = RSC_CAL_SETTLE;
               end
            end
         end
         RSC_CAL_SETTLE: begin
            // Wait covers the comparator settle time only, not its three-stage sync
            if (s.cal_cnt == 8'd1) begin
               next_s.cal_state = RSC_CAL_DECIDE;
            end
            next_s.cal_cnt = s.cal_cnt - 8'd1;
         end
         RSC_CAL_DECIDE: begin
            // Comparator high keeps the trial bit
            if (!s.cmp_level) begin
               kept = s.cal_code & ~mask;
            end
            next_s.cal_code = kept;
            if (s.cal_bit == 3'd0) begin
               next_s.cal_state = RSC_CAL_IDLE;
               next_s.cal_busy = 1'b0;
               next_s.cal_end = 1'b1;
               irq_set[`RSC_IRQ_CAL_END] = 1'b1;
               // Still short at full scale: out of range
               if (kept == 5'h1F && s.cmp_level) begin
                  next_s.cal_err = 1'b1;
                  irq_set[`RSC_IRQ_CAL_ERR] = 1'b1;
               end
            end else begin
               next_s.cal_bit = s.cal_bit - 3'd1;
               next_s.cal_code = kept | (mask >> 1);
               next_s.cal_cnt = SETTLE_CYC;
               next_s.cal_state = RSC_CAL_SETTLE;
            end
         end
         default: begin
            next_s.cal_state = RSC_CAL_IDLE;
            next_s.cal_busy = 1'b0;
         end
      endcase

      // Sticky status: a new event wins over a clear in the same cycle
      irq_set[`RSC_IRQ_RX_START] = rx_start;
      next_s.irq_status = (s.irq_status & ~irq_clr) | irq_set;
      next_s.irq = |(next_s.irq_status & next_s.irq_enable);

      // Read data is built in the setup cycle, so no wait state
      unique case (idx)
         `RSC_IDX_STRENGTH: begin
            rd = {am_strength_peak, pm_strength_peak};
         end
         `RSC_IDX_GAIN: begin
            rd = {s.gain_am, s.gain_pm};
         end
         `RSC_IDX_PROX_CTRL: begin
            rd = s.ctrl;
         end
         `RSC_IDX_PROX_DISP: begin
            rd = {s.cal_code, s.cal_end, s.cal_err, 1'b0};
         end
         `RSC_IDX_IRQ_STATUS: begin
            rd = {5'h00, s.irq_status};
         end
         `RSC_IDX_IRQ_ENABLE: begin
            rd = {5'h00, s.irq_enable};
         end
         default: begin
            rd = 8'h00;
         end
      endcase

      next_s.pready = setup;
      // Error flop follows ready, so the port needs no gate behind it
      next_s.pslverr = setup && !mapped;
      if (setup) begin
         next_s.prdata = (mapped && !PWRITE) ? {24'h00_0000, rd} :
            32'h0000_0000;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s <= '0;
         s.ctrl <= `RSC_PROX_CTRL_RST;
         s.irq_enable <= `RSC_IRQ_ENABLE_RST;
         s.cal_state <= RSC_CAL_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign PRDATA = s.prdata;
   assign PREADY = s.pready;
   assign PSLVERR = s.pslverr;
   assign CAP_CAL_CODE = s.cal_code;
   assign CAP_GAIN = s.ctrl[`RSC_GAIN_MSB:`RSC_GAIN_LSB];
   assign CAP_CAL_BUSY = s.cal_busy;
   assign IRQ = s.irq;

endmodule : rsc_regs

// ### sim/rsc_regs_chk.sv
// Port checker of the strength and proximity register group
`timescale 1ns/1ps
module rsc_regs_chk (
   input logic SYS_CLK,
   input logic RST_N,
   input logic PSEL,
   input logic PENABLE,
   input logic PWRITE,
   input logic [11:0] PADDR,
   input logic [31:0] PWDATA,
   input logic [31:0] PRDATA,
   input logic PREADY,
   input logic PSLVERR,
   input logic [4:0] CAP_CAL_CODE,
   input logic [2:0] CAP_GAIN,
   input logic CAP_CAL_BUSY,
   input logic IRQ
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready after setup");
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   err_with_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   misalign_err_a: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0
      |=> PSLVERR) else $error("misaligned address accepted");
   upper_zero_a: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == '0)
      else $error("read data upper bits set");
   gain_field_a: assert property (
      PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h0BC
      |=> CAP_GAIN == $past(PWDATA[2:0])) else $error("gain field lost");
   auto_start_a: assert property (
      $rose(CAP_CAL_BUSY) |-> CAP_CAL_CODE == 5'h10)
      else $error("auto calibration not at mid code");
   auto_hold_a: assert property (
      $rose(CAP_CAL_BUSY) |-> CAP_CAL_BUSY [*8])
      else $error("auto calibration too short");
   auto_bound_a: assert property (
      $rose(CAP_CAL_BUSY) |-> ##[500:520] $fell(CAP_CAL_BUSY))
      else $error("auto calibration length wrong");
   cover property ($rose(CAP_CAL_BUSY));
   cover property (PSLVERR);
   cover property ($rose(IRQ));
endmodule : rsc_regs_chk

bind rsc_regs rsc_regs_chk i_chk (.SYS_CLK, .RST_N, .PSEL, .PENABLE,
   .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CAP_CAL_CODE,
   .CAP_GAIN, .CAP_CAL_BUSY, .IRQ);

// ### sim/rsc_regs_tb_top.sv
// Self-checking bench of the strength and proximity register group
`timescale 1ns/1ps
`include "rsc_cfg.svh"
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin \
   miscompares++; $display("[ERR] %s exp %0h got %0h", n, x, g); end end
module rsc_regs_tb_top;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic rx = 0, cmp = 0, pready, pslverr, irq, busy, e;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic [3:0] amc = '0, pmc = '0, as = '0, aq = '0, aa = '0;
   logic [3:0] ps = '0, pq = '0, pa = '0;
   logic [4:0] code;
   logic [2:0] gain;
   int miscompares = 0, compares = 0;
   rsc_regs i_dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .AM_STRENGTH_CODE(amc), .PM_STRENGTH_CODE(pmc), .RX_ACTIVE(rx),
      .AM_GAIN_CUT_SETTING(as), .AM_SQUELCH_CUT(aq), .AM_AGC_CUT(aa),
      .PM_GAIN_CUT_SETTING(ps), .PM_SQUELCH_CUT(pq), .PM_AGC_CUT(pa),
      .CAP_CMP(cmp), .CAP_CAL_CODE(code), .CAP_GAIN(gain),
      .CAP_CAL_BUSY(busy), .IRQ(irq));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // Held until ready is sampled high, released after that edge only
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Ends once ready is seen high; otherwise only the watchdog ends it
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      `CHK("pready", 1'b1, pready)
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [7:0] x, string s);
      apb(1'b0, a, '0);
      `CHK(s, {24'h00_0000, x}, q)
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h00_0000, d});
   endtask : wr
   // Three-flop sync on the codes needs a few cycles to settle
   task automatic t_peak();
      amc <= 4'h3;
      pmc <= 4'h9;
      cyc(8);
      amc <= 4'h7;
      cyc(8);
      amc <= 4'h2;
      pmc <= 4'h1;
      cyc(8);
      rd(12'h0B4, 8'h79, "peak max");
      amc <= 4'h0;
      pmc <= 4'h0;
      wr(12'h0B4, 8'h00);
      cyc(6);
      rd(12'h0B4, 8'h79, "peak ro write");
      wr(12'h10C, 8'h01);
      cyc(3);
      rd(12'h0B4, 8'h00, "peak clear cmd");
      amc <= 4'h5;
      pmc <= 4'h1;
      cyc(8);
      rd(12'h0B4, 8'h51, "peak again");
      amc <= 4'h0;
      pmc <= 4'h0;
      cyc(6);
      rx <= 1'b1;
      cyc(8);
      rd(12'h0B4, 8'h00, "peak rx start");
      rd(12'h100, 8'h04, "rx start status");
      $display("peak test done");
   endtask : t_peak
   task automatic t_gain();
      as <= 4'h3;
      aq <= 4'h4;
      aa <= 4'h5;
      ps <= 4'h8;
      pq <= 4'h8;
      pa <= 4'h8;
      cyc(2);
      rd(12'h0B8, 8'hCF, "gain sum");
      {as, aq, aa, pq, pa} <= '0;
      ps <= 4'h1;
      cyc(2);
      rd(12'h0B8, 8'h01, "gain single");
      $display("gain test done");
   endtask : t_gain
   task automatic t_manual();
      logic [2:0] g[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
      rd(12'h0BC, 8'h00, "ctrl reset");
      rd(12'h104, 8'h00, "enable reset");
      foreach (g[i]) begin
         wr(12'h0BC, {5'h15, g[i]});
         `CHK("cap gain", g[i], gain)
         rd(12'h0BC, {5'h15, g[i]}, "ctrl rw");
      end
      wr(12'h10C, 8'h02);
      cyc(2);
      rd(12'h0C0, 8'hAC, "disp manual");
      `CHK("cal code", 5'h15, code)
      `CHK("no busy", 1'b0, busy)
      $display("manual test done");
   endtask : t_manual
   task automatic run_cal();
      int n;
      n = 0;
      wr(12'h10C, 8'h02);
      cyc(2);
      `CHK("busy", 1'b1, busy)
      while (busy !== 1'b0) begin
         cyc(1);
         n++;
      end
      `CHK("busy end", 1'b0, busy)
      // Five settle-plus-decide steps; the loop starts three edges late
      // and sees the fall one edge late
      `CHK("cal cycles", 5 * (`RSC_SETTLE_CYC + 1) - 2, n)
   endtask : run_cal
   task automatic t_auto();
      wr(12'h108, 8'h07);
      wr(12'h104, 8'h03);
      wr(12'h0BC, 8'h02);
      cmp <= 1'b1;
      cyc(4);
      run_cal();
      rd(12'h0C0, 8'hFE, "auto full");
      `CHK("irq set", 1'b1, irq)
      rd(12'h100, 8'h03, "status");
      wr(12'h104, 8'h00);
      cyc(2);
      `CHK("irq masked", 1'b0, irq)
      wr(12'h104, 8'h03);
      wr(12'h108, 8'h03);
      cyc(2);
      `CHK("irq cleared", 1'b0, irq)
      cmp <= 1'b0;
      cyc(4);
      run_cal();
      rd(12'h0C0, 8'h04, "auto low");
      $display("auto test done");
   endtask : t_auto
   task automatic t_bad();
      apb(1'b0, 12'h1F0, '0);
      `CHK("unmapped", 1'b1, e)
      apb(1'b0, 12'h0B5, '0);
      `CHK("misaligned", 1'b1, e)
      apb(1'b1, 12'h0C0, 32'h0000_00FF);
      `CHK("ro write", 1'b0, e)
      rd(12'h108, 8'h00, "wo read");
      $display("bus error test done");
   endtask : t_bad
   initial begin
      #100_000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      cyc(3);
      rst_n <= 1'b1;
      cyc(1);
      t_peak();
      t_gain();
      t_manual();
      t_auto();
      t_bad();
      tally_and_finish();
   end
endmodule : rsc_regs_tb_top
